// ### hw/mac_tx_regs.sv
// transmit-side mac control and status register bank
// assumes a host port on i_clock; mac, security and power logic on the same clock
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module mac_tx_regs
	import mac_tx_regs_pkg::*;
(
	input  wire logic       i_clock,
	input  wire logic       i_reset_n,
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	// events from the transmit mac
	input  wire logic       i_normal_done,
	input  wire logic [1:0] i_normal_retries,
	input  wire logic       i_normal_fail,
	input  wire logic       i_channel_busy_failure,
	input  wire logic       i_ack_pending_seen,
	input  wire logic       i_sq1_done,
	input  wire logic       i_sq1_fail,
	input  wire logic       i_sq1_time_short,
	input  wire logic [1:0] i_sq1_retries,
	input  wire logic       i_sq2_done,
	input  wire logic       i_sq2_fail,
	input  wire logic       i_sq2_time_short,
	input  wire logic [1:0] i_sq2_retries,
	input  wire logic       i_upper_mic_error,
	input  wire logic       i_low_battery,
	input  wire logic       i_beacon_irq_event,
	input  wire logic       i_rx_secure_frame,
	// controls to the transmit mac
	output logic            o_beacon_send_start,
	output logic            o_beacon_secure_enable,
	output logic            o_normal_send_start,
	output logic            o_normal_secure_enable,
	output logic            o_normal_ack_request,
	output logic            o_normal_indirect,
	output logic            o_slot_queue_one_start,
	output logic [7:0]      o_slot_queue_one_ctrl,
	output logic            o_slot_queue_two_start,
	output logic [7:0]      o_slot_queue_two_ctrl,
	output logic [7:0]      o_slot_allocation,
	output logic [19:0]     o_slot_ends,
	output logic [7:0]      o_fifo_tx_timing,
	output logic            o_slot_fifo_switch,
	output logic            o_immediate_wake_enable,
	output logic            o_register_wake_signal,
	output logic            o_beacon_irq,
	output logic            o_gts_clock_on,
	output logic [15:0]     o_half_symbol_timer,
	output logic            o_power_unit_reset,
	output logic            o_baseband_reset,
	output logic            o_mac_logic_reset,
	output logic            o_decrypt_start,
	output logic            o_decrypt_skip,
	output logic [5:0]      o_receive_cipher_kind,
	output logic [5:0]      o_normal_cipher_kind,
	output logic [5:0]      o_beacon_cipher_kind,
	output logic [8:0]      o_cipher_selects,
	output logic            o_sniffer_mode_bit,
	output logic            o_security_irq,
	output logic            o_encrypt_active,
	output logic [7:0]      o_calibration_tuning
);

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function automatic logic wr_at(input logic [7:0] a);
		return i_wr && (i_addr == a);
	endfunction

	function automatic cipher_kind_e cipher_kind(input logic [2:0] c);
		cipher_kind_e k;
		k = C_OTHER;
		case (c)
			CIPH_NONE:   k = C_NONE;
			CIPH_CTR:    k = C_CTR;
			CIPH_CCM128: k = C_CCM;
			CIPH_CCM64:  k = C_CCM;
			CIPH_CCM32:  k = C_CCM;
			CIPH_CBC128: k = C_CBC;
			default:     k = C_OTHER;
		endcase
		return k;
	endfunction

	// ----------------------------------------
	// plain read-write registers
	// ----------------------------------------
	logic [7:0] slot_alloc_q, timing_q, end23_q, end45_q, end6_q, switch_q;
	logic [7:0] wake_q, bmask_q, gate_q, hsym_lo_q, hsym_hi_q, calib_q;
	logic [5:0] seca_q;
	logic [7:0] secb_q;
	logic [1:0] bcn_cfg_q;
	logic [3:0] nrm_cfg_q;
	logic [5:0] sq1_cfg_q, sq2_cfg_q;
	logic [1:0] sq1_lim_q, sq2_lim_q, sq1_used_q, sq2_used_q;

	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			slot_alloc_q <= 8'h00;
			timing_q     <= FIFO_TIMING_RESET;
			end23_q      <= 8'h00;
			end45_q      <= 8'h00;
			end6_q       <= 8'h00;
			switch_q     <= 8'h00;
			wake_q       <= 8'h00;
			bmask_q      <= 8'h00;
			gate_q       <= 8'h00;
			hsym_lo_q    <= 8'h00;
			hsym_hi_q    <= 8'h00;
			seca_q       <= 6'h00;
			secb_q       <= 8'h00;
			calib_q      <= CALIB_RESET;
		end else begin
			if (wr_at(ADDR_SLOT_ALLOC))  slot_alloc_q <= i_wdata; // [R1]
			if (wr_at(ADDR_FIFO_TIMING)) timing_q <= i_wdata & FIFO_TIMING_MASK; // [R4] [R5] [R24]
			if (wr_at(ADDR_SLOT_END_23)) end23_q <= i_wdata; // [R2]
			if (wr_at(ADDR_SLOT_END_45)) end45_q <= i_wdata; // [R2]
			if (wr_at(ADDR_SLOT_END_6))  end6_q <= i_wdata & SLOT_END_6_MASK; // [R2] [R24]
			if (wr_at(ADDR_SLOT_SWITCH)) switch_q <= i_wdata & SLOT_SWITCH_MASK;
			if (wr_at(ADDR_WAKE_CTRL))   wake_q <= i_wdata & WAKE_CTRL_MASK; // [R12]
			if (wr_at(ADDR_BCN_MASK))    bmask_q <= i_wdata & BCN_MASK_MASK; // [R16]
			if (wr_at(ADDR_CLK_GATING))  gate_q <= i_wdata & CLK_GATING_MASK;
			if (wr_at(ADDR_HSYM_LOW))    hsym_lo_q <= i_wdata; // [R17]
			if (wr_at(ADDR_HSYM_HIGH))   hsym_hi_q <= i_wdata; // [R17]
			if (wr_at(ADDR_SEC_A))       seca_q <= i_wdata[5:0]; // [R20]
			if (wr_at(ADDR_SEC_B))       secb_q <= i_wdata & SEC_B_MASK; // [R20] [R22]
			if (wr_at(ADDR_CALIB))       calib_q <= i_wdata;
		end
	end

	// ----------------------------------------
	// trigger registers
	// ----------------------------------------
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			bcn_cfg_q <= 2'h0;
			nrm_cfg_q <= 4'h0;
			sq1_cfg_q <= 6'h00;
			sq2_cfg_q <= 6'h00;
			sq1_lim_q <= 2'h0;
			sq2_lim_q <= 2'h0;
		end else begin
			if (wr_at(ADDR_BCN_TRIG)) bcn_cfg_q <= {i_wdata[BIT_SECURE], 1'b0}; // [R6]
			if (wr_at(ADDR_NRM_TRIG)) nrm_cfg_q <= {i_wdata[BIT_INDIR:BIT_SECURE], 1'b0}; // [R7] [R8]
			if (wr_at(ADDR_SQ1_TRIG)) begin
				sq1_cfg_q <= {i_wdata[5:1], 1'b0}; // [R10]
				sq1_lim_q <= i_wdata[7:6]; // [R11]
			end
			if (wr_at(ADDR_SQ2_TRIG)) begin
				sq2_cfg_q <= {i_wdata[5:1], 1'b0}; // [R10]
				sq2_lim_q <= i_wdata[7:6]; // [R11]
			end
		end
	end

	// one-cycle pulses; hardware clears them in the following cycle
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			o_beacon_send_start    <= 1'b0;
			o_normal_send_start    <= 1'b0;
			o_slot_queue_one_start <= 1'b0;
			o_slot_queue_two_start <= 1'b0;
			o_power_unit_reset     <= 1'b0;
			o_baseband_reset       <= 1'b0;
			o_mac_logic_reset      <= 1'b0;
			o_decrypt_start        <= 1'b0;
			o_decrypt_skip         <= 1'b0;
		end else begin
			o_beacon_send_start    <= wr_at(ADDR_BCN_TRIG) & i_wdata[BIT_START]; // [R6] [R23]
			o_normal_send_start    <= wr_at(ADDR_NRM_TRIG) & i_wdata[BIT_START]; // [R7] [R23]
			o_slot_queue_one_start <= wr_at(ADDR_SQ1_TRIG) & i_wdata[BIT_START]; // [R23]
			o_slot_queue_two_start <= wr_at(ADDR_SQ2_TRIG) & i_wdata[BIT_START]; // [R23]
			o_power_unit_reset     <= wr_at(ADDR_SOFT_RESET) & i_wdata[2]; // [R18]
			o_baseband_reset       <= wr_at(ADDR_SOFT_RESET) & i_wdata[1]; // [R18]
			o_mac_logic_reset      <= wr_at(ADDR_SOFT_RESET) & i_wdata[0]; // [R18]
			o_decrypt_start        <= wr_at(ADDR_SEC_A) & i_wdata[BIT_DSTART]; // [R19] [R23]
			o_decrypt_skip         <= wr_at(ADDR_SEC_A) & i_wdata[BIT_SKIP]; // [R19] [R23]
		end
	end

	// ----------------------------------------
	// status capture from the mac
	// ----------------------------------------
	logic [7:0] transmit_status_q;
	logic       pend_q, upsec_q, batt_q;

	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			transmit_status_q     <= 8'h00;
			pend_q     <= 1'b0;
			sq1_used_q <= 2'h0;
			sq2_used_q <= 2'h0;
			batt_q     <= 1'b0;
		end else begin
			batt_q <= i_low_battery;
			if (i_normal_done) begin
				transmit_status_q[7:6] <= i_normal_retries; // [R13]
				transmit_status_q[0]   <= i_normal_fail; // [R15]
				transmit_status_q[5]   <= i_channel_busy_failure; // [R13]
				pend_q      <= i_ack_pending_seen; // [R9]
			end
			if (i_sq1_done) begin
				transmit_status_q[1] <= i_sq1_fail; // [R15]
				transmit_status_q[3] <= i_sq1_time_short; // [R14]
				if (!i_sq1_fail && !i_sq1_time_short) sq1_used_q <= i_sq1_retries; // [R11]
			end
			if (i_sq2_done) begin
				transmit_status_q[2] <= i_sq2_fail; // [R15]
				transmit_status_q[4] <= i_sq2_time_short; // [R14]
				if (!i_sq2_fail && !i_sq2_time_short) sq2_used_q <= i_sq2_retries; // [R11]
			end
		end
	end

	// set wins over a write-one clear in the same cycle
	always_ff @(posedge i_clock) begin
		if (!i_reset_n)
			upsec_q <= 1'b0;
		else if (i_upper_mic_error)
			upsec_q <= 1'b1;
		else if (wr_at(ADDR_RX_STATUS) && i_wdata[BIT_UPSEC])
			upsec_q <= 1'b0;
	end

	// ----------------------------------------
	// derived controls
	// ----------------------------------------
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			o_beacon_irq     <= 1'b0;
			o_security_irq   <= 1'b0;
			o_encrypt_active <= 1'b0;
		end else begin
			o_beacon_irq   <= i_beacon_irq_event & ~bmask_q[7]; // [R16]
			o_security_irq <= i_rx_secure_frame & ~secb_q[1]; // [R21]
			o_encrypt_active <= (nrm_cfg_q[BIT_SECURE] | bcn_cfg_q[BIT_SECURE])
				& ~secb_q[0]; // [R21]
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			o_beacon_secure_enable  <= 1'b0;
			o_normal_secure_enable  <= 1'b0;
			o_normal_ack_request    <= 1'b0;
			o_normal_indirect       <= 1'b0;
			o_slot_queue_one_ctrl   <= 8'h00;
			o_slot_queue_two_ctrl   <= 8'h00;
			o_slot_allocation       <= 8'h00;
			o_slot_ends             <= 20'h00000;
			o_fifo_tx_timing        <= FIFO_TIMING_RESET;
			o_slot_fifo_switch      <= 1'b0;
			o_immediate_wake_enable <= 1'b0;
			o_register_wake_signal  <= 1'b0;
			o_gts_clock_on          <= 1'b0;
			o_half_symbol_timer     <= 16'h0000;
			o_receive_cipher_kind   <= C_NONE;
			o_normal_cipher_kind    <= C_NONE;
			o_beacon_cipher_kind    <= C_NONE;
			o_cipher_selects        <= 9'h000;
			o_sniffer_mode_bit      <= 1'b0;
			o_calibration_tuning    <= CALIB_RESET;
		end else begin
			o_beacon_secure_enable  <= bcn_cfg_q[BIT_SECURE] & ~secb_q[0]; // [R6] [R21]
			o_normal_secure_enable  <= nrm_cfg_q[BIT_SECURE] & ~secb_q[0]; // [R7] [R21]
			o_normal_ack_request    <= nrm_cfg_q[BIT_ACKREQ]; // [R8]
			o_normal_indirect       <= nrm_cfg_q[BIT_INDIR];
			o_slot_queue_one_ctrl   <= {sq1_lim_q, sq1_cfg_q}; // [R10] [R11]
			o_slot_queue_two_ctrl   <= {sq2_lim_q, sq2_cfg_q}; // [R10] [R11]
			o_slot_allocation       <= slot_alloc_q; // [R1]
			o_slot_ends             <= {end6_q[3:0], end45_q, end23_q}; // [R2]
			o_fifo_tx_timing        <= timing_q; // [R3] [R4] [R5]
			o_slot_fifo_switch      <= switch_q[1];
			o_immediate_wake_enable <= wake_q[7]; // [R12]
			o_register_wake_signal  <= wake_q[6]; // [R12]
			o_gts_clock_on          <= gate_q[3];
			o_half_symbol_timer     <= {hsym_hi_q, hsym_lo_q}; // [R17]
			o_receive_cipher_kind   <= cipher_kind(seca_q[5:3]); // [R20]
			o_normal_cipher_kind    <= cipher_kind(seca_q[2:0]); // [R20]
			o_beacon_cipher_kind    <= cipher_kind(secb_q[6:4]); // [R20]
			o_cipher_selects        <= {secb_q[6:4], seca_q}; // [R20]
			o_sniffer_mode_bit      <= secb_q[3];
			o_calibration_tuning    <= calib_q;
		end
	end

	// ----------------------------------------
	// read port
	// ----------------------------------------
	logic [7:0] rd_d;

	always_comb begin
		rd_d = 8'h00; // [R24]
		case (i_addr)
			ADDR_SLOT_ALLOC:  rd_d = slot_alloc_q;
			ADDR_FIFO_TIMING: rd_d = timing_q;
			ADDR_BCN_TRIG:    rd_d = {6'h00, bcn_cfg_q};
			ADDR_NRM_TRIG:    rd_d = {3'h0, pend_q, nrm_cfg_q}; // [R9]
			ADDR_SQ1_TRIG:    rd_d = {sq1_used_q, sq1_cfg_q}; // [R11]
			ADDR_SQ2_TRIG:    rd_d = {sq2_used_q, sq2_cfg_q}; // [R11]
			ADDR_SLOT_END_23: rd_d = end23_q;
			ADDR_SLOT_END_45: rd_d = end45_q;
			ADDR_SLOT_END_6:  rd_d = end6_q;
			ADDR_SLOT_SWITCH: rd_d = switch_q;
			ADDR_WAKE_CTRL:   rd_d = wake_q;
			ADDR_TX_STATUS:   rd_d = transmit_status_q; // [R13] [R14] [R15]
			ADDR_BCN_MASK:    rd_d = bmask_q;
			ADDR_CLK_GATING:  rd_d = gate_q;
			ADDR_HSYM_LOW:    rd_d = hsym_lo_q;
			ADDR_HSYM_HIGH:   rd_d = hsym_hi_q;
			ADDR_SEC_A:       rd_d = {2'h0, seca_q};
			ADDR_SEC_B:       rd_d = secb_q;
			ADDR_CALIB:       rd_d = calib_q;
			ADDR_RX_STATUS:   rd_d = {1'b0, upsec_q, batt_q, 5'h00};
			default:          rd_d = 8'h00;
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (!i_reset_n)
			o_rdata <= 8'h00;
		else if (i_rd)
			o_rdata <= rd_d;
		else
			o_rdata <= 8'h00;
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_trig_self_clear: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R23]
		o_normal_send_start |=> !o_normal_send_start || $past(wr_at(ADDR_NRM_TRIG)))
		else $error("normal start pulse did not self clear");
	chk_beacon_start: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R6]
		wr_at(ADDR_BCN_TRIG) && i_wdata[0] |=> o_beacon_send_start)
		else $error("beacon start missing");
	chk_normal_start: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R7]
		$rose(o_normal_send_start) |-> $past(wr_at(ADDR_NRM_TRIG) && i_wdata[0]))
		else $error("normal start without write");
	chk_mac_reset: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R18]
		wr_at(ADDR_SOFT_RESET) && i_wdata[0] |=> o_mac_logic_reset ##1 !o_mac_logic_reset
			|| $past(wr_at(ADDR_SOFT_RESET)))
		else $error("mac reset pulse wrong");
	chk_decrypt_start: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R19]
		wr_at(ADDR_SEC_A) && i_wdata[6] |=> o_decrypt_start)
		else $error("decrypt start missing");
	chk_timer_value: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R17]
		wr_at(ADDR_HSYM_HIGH) |=> ##1 o_half_symbol_timer[15:8] == $past(i_wdata, 2))
		else $error("timer high byte wrong");
	chk_no_encrypt: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R21]
		secb_q[0] && $past(secb_q[0]) |-> !o_encrypt_active)
		else $error("encryption while disabled");
	chk_beacon_masked: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R16]
		bmask_q[7] && $past(bmask_q[7]) |-> !o_beacon_irq)
		else $error("masked beacon irq seen");
	chk_read_timing: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R13]
		i_rd && i_addr == ADDR_TX_STATUS |=> o_rdata == $past(transmit_status_q))
		else $error("status read wrong");
	chk_reserved_zero: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R24]
		i_rd && i_addr == ADDR_SLOT_END_6 |=> o_rdata[7:4] == 4'h0)
		else $error("reserved bits not zero");

	cov_beacon_send: cover property (@(posedge i_clock) o_beacon_send_start);
	cov_normal_fail: cover property (@(posedge i_clock) i_normal_done && i_normal_fail);
	cov_sq1_good:    cover property (@(posedge i_clock) i_sq1_done && !i_sq1_fail);
	cov_status_read: cover property (@(posedge i_clock) i_rd && i_addr == ADDR_TX_STATUS);
endmodule
`default_nettype wire

// ### hw/mac_tx_regs_pkg.sv
// constants for the transmit-side mac control register bank
// assumes an 8-bit register port with byte addresses equal to register offsets
//
// Notes on behaviour
// [R1] slot allocation: contention end slot bits 3-0, first guaranteed end 7-4, reset zero
// [R2] guaranteed slots two to six each have a 4-bit end-slot field
// [R3] host keeps queue output enable at one; zero is forbidden
// [R4] pre-send symbol count bits 5-2 resets to 2; host never writes below 1
// [R5] pre-send radio period bits 1-0 resets to zero
// [R6] beacon trigger bit 0 starts beacon send; bit 1 secures it
// [R7] normal trigger bit 0 starts normal send; bit 1 requests encryption
// [R8] ack request bit 2 makes the mac await an ack and retry
// [R9] normal trigger bit 4 reads the pending flag of the received ack
// [R10] slot queue triggers hold slot number in bits 5-3 plus ack, secure, start
// [R11] slot queue retry field: written limit, read retries of last good frame
// [R12] wake control: immediate wake bit 7, register wake bit 6 cleared by host
// [R13] transmit status: normal retries bits 7-6, channel busy failure bit 5
// [R14] status bits 4 and 3: slot queue two or one ran out of slot time
// [R15] status bits 2,1,0: release failure of slot two, slot one, normal queue
// [R16] beacon mask bit 7 masks the beacon interrupt, resets zero
// [R17] 16-bit half-symbol timer, low byte then high byte, reset zero
// [R18] soft reset bits 2,1,0 reset power unit, baseband, mac
// [R19] security a bit 6 starts decryption, bit 7 skips it
// [R20] cipher codes: none, counter, ccm 128/64/32, cbc-mac 128
// [R21] decrypt disable blocks security interrupt; encrypt disable blocks encryption; slot queue secure bits still reach the mac ungated
// [R22] host keeps sniffer mode zero while using the half-symbol timer
// [R23] trigger bits act on a written one then clear themselves
// [R24] reserved bits read zero and ignore writes
package mac_tx_regs_pkg;
	localparam logic [7:0] ADDR_SLOT_ALLOC   = 8'h13;
	localparam logic [7:0] ADDR_FIFO_TIMING  = 8'h18;
	localparam logic [7:0] ADDR_BCN_TRIG     = 8'h1A;
	localparam logic [7:0] ADDR_NRM_TRIG     = 8'h1B;
	localparam logic [7:0] ADDR_SQ1_TRIG     = 8'h1C;
	localparam logic [7:0] ADDR_SQ2_TRIG     = 8'h1D;
	localparam logic [7:0] ADDR_SLOT_END_23  = 8'h1E;
	localparam logic [7:0] ADDR_SLOT_END_45  = 8'h1F;
	localparam logic [7:0] ADDR_SLOT_END_6   = 8'h20;
	localparam logic [7:0] ADDR_SLOT_SWITCH  = 8'h21;
	localparam logic [7:0] ADDR_WAKE_CTRL    = 8'h22;
	localparam logic [7:0] ADDR_TX_STATUS    = 8'h24;
	localparam logic [7:0] ADDR_BCN_MASK     = 8'h25;
	localparam logic [7:0] ADDR_CLK_GATING   = 8'h26;
	localparam logic [7:0] ADDR_HSYM_LOW     = 8'h28;
	localparam logic [7:0] ADDR_HSYM_HIGH    = 8'h29;
	localparam logic [7:0] ADDR_SOFT_RESET   = 8'h2A;
	localparam logic [7:0] ADDR_SEC_A        = 8'h2C;
	localparam logic [7:0] ADDR_SEC_B        = 8'h2D;
	localparam logic [7:0] ADDR_CALIB        = 8'h2E;
	localparam logic [7:0] ADDR_RX_STATUS    = 8'h30;

	localparam logic [7:0] FIFO_TIMING_RESET = 8'h88;
	localparam logic [7:0] CALIB_RESET       = 8'h75;
	localparam logic [7:0] FIFO_TIMING_MASK  = 8'hBF;
	localparam logic [7:0] SLOT_SWITCH_MASK  = 8'h02;
	localparam logic [7:0] WAKE_CTRL_MASK    = 8'hC0;
	localparam logic [7:0] CLK_GATING_MASK   = 8'h08;
	localparam logic [7:0] SEC_B_MASK        = 8'h7B;
	localparam logic [7:0] BCN_MASK_MASK     = 8'h80;
	localparam logic [7:0] SLOT_END_6_MASK   = 8'h0F;

	localparam int BIT_START   = 0;
	localparam int BIT_SECURE  = 1;
	localparam int BIT_ACKREQ  = 2;
	localparam int BIT_INDIR   = 3;
	localparam int BIT_ACK_PENDING_SEEN = 4;
	localparam int BIT_SKIP    = 7;
	localparam int BIT_DSTART  = 6;
	localparam int BIT_UPSEC   = 6;
	localparam int BIT_BATT    = 5;

	localparam logic [2:0] CIPH_NONE    = 3'h0;
	localparam logic [2:0] CIPH_CTR     = 3'h1;
	localparam logic [2:0] CIPH_CCM128  = 3'h2;
	localparam logic [2:0] CIPH_CCM64   = 3'h3;
	localparam logic [2:0] CIPH_CCM32   = 3'h4;
	localparam logic [2:0] CIPH_CBC128  = 3'h5;

	typedef enum logic [5:0] {
		C_NONE   = 6'b000001,
		C_CTR    = 6'b000010,
		C_CCM    = 6'b000100,
		C_CBC    = 6'b001000,
		C_OTHER  = 6'b010000,
		C_UNUSED = 6'b100000
	} cipher_kind_e;
endpackage

// ### test/mac_host_model.sv
// host-side master for the register port of the transmit register bank
// assumes the bank takes strobes on the rising edge of i_clock
`timescale 1ns/10ps
`default_nettype none
module mac_host_model
	import mac_tx_regs_pkg::*;
(
	input  wire logic       i_clock,
	input  wire logic [7:0] i_rdata,
	output var  logic [7:0] o_addr,
	output var  logic [7:0] o_wdata,
	output var  logic       o_wr,
	output var  logic       o_rd
);
	// ------------------------------------------------
	// bus cycles
	// ------------------------------------------------
	initial begin
		o_addr = 8'h00;
		o_wdata = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end

	task automatic put(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (a == ADDR_FIFO_TIMING) begin
			v[7] = 1'b1;
			if (v[5:2] == 4'h0) begin
				v[5:2] = 4'h1;
			end
		end
		if (a == ADDR_SEC_B) begin
			v[3] = 1'b0;  // the timer stays in use throughout
		end
		@(posedge i_clock);
		o_addr  <= a;
		o_wdata <= v;
		o_wr    <= 1'b1;
		@(posedge i_clock);
		o_wr    <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic get(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clock);
		o_addr <= a;
		o_rd   <= 1'b1;
		@(posedge i_clock);
		o_rd   <= 1'b0;
		#1;
		d = i_rdata;
	endtask
endmodule
`default_nettype wire

// ### test/test_mac_tx_regs.sv
// self-checking bench for the transmit register bank
// assumes the host model drives the register port and the bench drives mac events
`timescale 1ns/10ps
`default_nettype none
module test_mac_tx_regs;
	import mac_tx_regs_pkg::*;
	logic       i_clock, i_reset_n, i_wr, i_rd;
	logic [7:0] i_addr, i_wdata, o_rdata;
	logic       i_normal_done, i_normal_fail, i_channel_busy_failure, i_ack_pending_seen;
	logic       i_sq1_done, i_sq1_fail, i_sq1_time_short, i_sq2_done, i_sq2_fail;
	logic       i_sq2_time_short, i_upper_mic_error, i_low_battery, i_beacon_irq_event;
	logic       i_rx_secure_frame, o_beacon_irq, o_security_irq, o_normal_secure_enable;
	logic       o_beacon_secure_enable, o_encrypt_active, o_immediate_wake_enable;
	logic       o_register_wake_signal;
	logic [7:0] o_fifo_tx_timing;
	logic [19:0] o_slot_ends;
	logic       o_beacon_send_start, o_normal_send_start, o_normal_ack_request;
	logic       o_slot_queue_one_start, o_slot_queue_two_start, o_decrypt_start, o_decrypt_skip;
	logic       o_power_unit_reset, o_baseband_reset, o_mac_logic_reset;
	logic [1:0] i_normal_retries, i_sq1_retries, i_sq2_retries;
	logic [5:0] o_normal_cipher_kind;
	logic [7:0] o_slot_allocation;
	logic [15:0] o_half_symbol_timer;
	int         fail_count = 0;
	int         num_checks = 0;
	logic [7:0] ra[12] = '{8'h13, 8'h18, 8'h1E, 8'h1F, 8'h20, 8'h21, 8'h22, 8'h25, 8'h26,
		8'h28, 8'h29, 8'h3F};
	logic [7:0] rm[12] = '{8'hFF, 8'hBF, 8'hFF, 8'hFF, 8'h0F, 8'h02, 8'hC0, 8'h80, 8'h08,
		8'hFF, 8'hFF, 8'h00};
	logic [7:0] ta[4] = '{8'h1A, 8'h1B, 8'h1C, 8'h1D};
	logic [7:0] tr[4] = '{8'h02, 8'h06, 8'h06, 8'h06};
	logic [5:0] ck[8] = '{6'h01, 6'h02, 6'h04, 6'h04, 6'h04, 6'h08, 6'h10, 6'h10};

	mac_host_model host (.i_clock, .i_rdata(o_rdata), .o_addr(i_addr), .o_wdata(i_wdata),
		.o_wr(i_wr), .o_rd(i_rd));
	mac_tx_regs uut (.i_clock, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
		.i_normal_done, .i_normal_retries, .i_normal_fail, .i_channel_busy_failure,
		.i_ack_pending_seen, .i_sq1_done, .i_sq1_fail, .i_sq1_time_short, .i_sq1_retries,
		.i_sq2_done, .i_sq2_fail, .i_sq2_time_short, .i_sq2_retries, .i_upper_mic_error,
		.i_low_battery, .i_beacon_irq_event, .i_rx_secure_frame, .o_beacon_send_start,
		.o_beacon_secure_enable, .o_normal_send_start, .o_normal_secure_enable,
		.o_normal_ack_request, .o_normal_indirect(), .o_slot_queue_one_start,
		.o_slot_queue_one_ctrl(), .o_slot_queue_two_start, .o_slot_queue_two_ctrl(),
		.o_slot_allocation, .o_slot_ends, .o_fifo_tx_timing, .o_slot_fifo_switch(),
		.o_immediate_wake_enable, .o_register_wake_signal, .o_beacon_irq,
		.o_gts_clock_on(), .o_half_symbol_timer, .o_power_unit_reset, .o_baseband_reset,
		.o_mac_logic_reset, .o_decrypt_start, .o_decrypt_skip, .o_receive_cipher_kind(),
		.o_normal_cipher_kind, .o_beacon_cipher_kind(), .o_cipher_selects(),
		.o_sniffer_mode_bit(), .o_security_irq, .o_encrypt_active,
		.o_calibration_tuning());

	// ------------------------------------------------
	// helpers
	// ------------------------------------------------
	initial begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		host.get(a, d);
		chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, d});
	endtask

	// all three queues report at once so that one call covers every status field
	task automatic fire(input logic [10:0] v);
		@(posedge i_clock);
		{i_normal_retries, i_normal_fail, i_channel_busy_failure, i_ack_pending_seen,
			i_sq1_fail, i_sq1_time_short, i_sq1_retries, i_sq2_fail, i_sq2_time_short} <= v;
		{i_normal_done, i_sq1_done, i_sq2_done} <= 3'b111;
		@(posedge i_clock);
		{i_normal_done, i_sq1_done, i_sq2_done} <= 3'b000;
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		#200000;
		fail_count++;
		end_sim();
	end

	// ------------------------------------------------
	// tests
	// ------------------------------------------------
	initial begin
		i_reset_n = 1'b0;
		{i_normal_done, i_normal_fail, i_channel_busy_failure, i_ack_pending_seen, i_sq1_done,
			i_sq1_fail, i_sq1_time_short, i_sq2_done, i_sq2_fail, i_sq2_time_short,
			i_upper_mic_error, i_low_battery, i_beacon_irq_event, i_rx_secure_frame,
			i_normal_retries, i_sq1_retries, i_sq2_retries} = '0;
		repeat (10) @(posedge i_clock);
		i_reset_n <= 1'b1;
		rchk(ADDR_FIFO_TIMING, 8'h88);
		rchk(ADDR_SLOT_ALLOC, 8'h00);
		rchk(ADDR_HSYM_HIGH, 8'h00);
		rchk(ADDR_BCN_MASK, 8'h00);
		rchk(ADDR_TX_STATUS, 8'h00);
		$display("test reset_values done");
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 12; i++) begin
				host.put(ra[i], p == 0 ? 8'hFF : 8'hA5);
				rchk(ra[i], (p == 0 ? 8'hFF : 8'hA5) & rm[i]);
			end
		end
		chk("wake", 16'h0002, {14'h0, o_immediate_wake_enable,
			o_register_wake_signal});
		host.put(ADDR_WAKE_CTRL, 8'h00);
		chk("alloc", 16'h00A5, {8'h00, o_slot_allocation});
		chk("timer", 16'hA5A5, o_half_symbol_timer);
		chk("ends", 16'h5A5A, o_slot_ends[19:4]);
		chk("timing", 16'h00A5, {8'h00, o_fifo_tx_timing});
		$display("test read_write done");
		@(posedge i_clock);
		i_beacon_irq_event <= 1'b1;
		repeat (2) @(posedge i_clock);
		#1;
		chk("bcn irq masked", 16'h0000, {15'h0, o_beacon_irq});
		host.put(ADDR_BCN_MASK, 8'h00);
		repeat (2) @(posedge i_clock);
		#1;
		chk("bcn irq open", 16'h0001, {15'h0, o_beacon_irq});
		$display("test beacon_mask done");
		for (int i = 0; i < 4; i++) begin
			host.put(ta[i], 8'h07);
			#1;
			chk("start", 16'h0008 >> i, {12'h0, o_beacon_send_start, o_normal_send_start,
				o_slot_queue_one_start, o_slot_queue_two_start});
			rchk(ta[i], tr[i]);
		end
		chk("ack req", 16'h0001, {15'h0, o_normal_ack_request});
		$display("test triggers done");
		fire(11'b10111001101);
		rchk(ADDR_TX_STATUS, 8'hB1);
		rchk(ADDR_SQ1_TRIG, 8'hC6);
		rchk(ADDR_NRM_TRIG, 8'h16);
		fire(11'b01000010010);
		rchk(ADDR_TX_STATUS, 8'h4C);
		rchk(ADDR_SQ1_TRIG, 8'hC6);
		rchk(ADDR_NRM_TRIG, 8'h06);
		$display("test status done");
		for (int i = 0; i < 8; i++) begin
			host.put(ADDR_SEC_A, {5'b11000, i[2:0]});
			#1;
			chk("dec", 16'h0003, {14'h0, o_decrypt_start, o_decrypt_skip});
			@(posedge i_clock);
			#1;
			chk("cipher", {10'h0, ck[i]}, {10'h0, o_normal_cipher_kind});
		end
		@(posedge i_clock);
		i_rx_secure_frame <= 1'b1;
		host.put(ADDR_SEC_B, 8'h03);
		repeat (2) @(posedge i_clock);
		#1;
		chk("sec off", 16'h0000, {12'h0, o_beacon_secure_enable, o_encrypt_active,
			o_security_irq, o_normal_secure_enable});
		host.put(ADDR_SEC_B, 8'h00);
		repeat (2) @(posedge i_clock);
		#1;
		chk("sec on", 16'h000F, {12'h0, o_beacon_secure_enable, o_encrypt_active,
			o_security_irq, o_normal_secure_enable});
		@(posedge i_clock);
		i_low_battery     <= 1'b1;
		i_upper_mic_error <= 1'b1;
		@(posedge i_clock);
		i_upper_mic_error <= 1'b0;
		rchk(ADDR_RX_STATUS, 8'h60);
		host.put(ADDR_RX_STATUS, 8'h40);
		rchk(ADDR_RX_STATUS, 8'h20);
		$display("test security done");
		for (int i = 0; i < 3; i++) begin
			host.put(ADDR_SOFT_RESET, 8'h01 << i);
			#1;
			chk("soft", 16'h0001 << i, {13'h0, o_power_unit_reset, o_baseband_reset,
				o_mac_logic_reset});
			rchk(ADDR_SOFT_RESET, 8'h00);
		end
		$display("test soft_reset done");
		end_sim();
	end
endmodule
`default_nettype wire
